/* File: rtl/release_countdown_abort_control.v */
// release countdown with abort modes, release output and thermal cycling
//
// Behaviour
// - reload mode: abort activation reloads countdown to full delay
// - reload mode: restart from full delay on release; reload on reassert
// - countdown state held in every mode until system reset clears it
// - floor mode: keep counting under abort, stop at ten seconds
// - floor mode: resume from ten; abort below ten sets back to ten
// - extended mode: abort loads full delay plus ninety seconds
// - extended mode: count from delay plus ninety; reload on reassert
// - freeze mode: hold count under abort, continue after release
// - no-interrupt mode: floor mode but abort ignored once decrementing
// - solenoid output for 90 s, 10 min, 15 min, continuous or cycling
// - module in up to four groups, at most sixteen modules per group
// - thermal cycling follows heat detector alarm states
// - non-cycling alarm input cancels thermal cycling
// - after override, release latched until system reset
// - per-input polarity for normally-open or normally-closed contacts
// - per-module release type, non-power-limited and two-solenoid flags
// - first heat alarm: on for initial cutoff, reactivate if still alarm
// - later cycles use cyclical cutoff; 0..180 seconds or minutes
//
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "release_ctl_defs.vh"
module release_countdown_abort_control #(
    parameter NMOD = 16,
    parameter NGRP = 4,
    parameter [31:0] SEC_CYCLES = `CLK_HZ
)(
    // bus
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // contact inputs
    input wire abort_in,
    input wire heat_in,
    input wire alarm_initiating_input,
    // release outputs
    output reg [NMOD-1:0] release_out,
    output reg countdown_done
);
    localparam [31:0] SEC_MAX = SEC_CYCLES - 32'h1;
    reg [2:0] mode_ff;
    reg [2:0] act_ff;
    reg running_ff;
    reg [15:0] delay_ff;
    reg [2:0] pol_ff;
    reg [3*NMOD-1:0] modcfg_ff;
    reg [7:0] itl_ff;
    reg [7:0] ctl_ff;
    reg unit_min_ff;
    reg [4*NMOD-1:0] grp_ff;
    reg [NGRP-1:0] rel_grp_ff;
    reg [15:0] cnt_ff;
    reg started_ff;
    reg dec_ff;
    reg abort_d_ff;
    reg [31:0] pre_ff;
    reg [15:0] act_cnt_ff;
    reg [7:0] cyc_cnt_ff;
    reg [5:0] min_ff;
    reg cyc_on_ff;
    reg first_ff;
    reg latched_ff;
    reg act_fired_ff;
    reg [3:0] mod_idx_ff;
    reg rel_ff;
    reg heat_d_ff;
    reg wr_ff;
    reg rd_ff;
    reg [11:0] addr_ff;
    wire abort_a;
    wire heat_a;
    wire other_a;
    wire tick;
    wire abort_rise;
    wire heat_rise;
    wire unit_tick;
    wire [7:0] cut_len;
    wire [15:0] act_len;
    wire [15:0] full_ext;
    reg [15:0] nxt_cnt;
    reg nxt_dec;
    integer i;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // contact polarity
    assign abort_a = abort_in ^ pol_ff[0];
    assign heat_a = heat_in ^ pol_ff[1];
    assign other_a = alarm_initiating_input ^ pol_ff[2];
    assign tick = (pre_ff == SEC_MAX);
    assign abort_rise = abort_a & ~abort_d_ff;
    assign heat_rise = heat_a & ~heat_d_ff;
    assign full_ext = delay_ff + `EXTRA_SEC;
    assign unit_tick = tick & (~unit_min_ff | (min_ff == 6'h3b));
    assign cut_len = first_ff ? itl_ff : ctl_ff;
    assign act_len = (act_ff == `ACT_10M) ? `ACT10M_SEC :
                     (act_ff == `ACT_15M) ? `ACT15M_SEC : `ACT90_SEC;
    // one-second timebase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pre_ff <= 32'h0;
        else if (tick)
            pre_ff <= 32'h0;
        else
            pre_ff <= pre_ff + 32'h1;
    end
    // countdown next value by abort mode
    always @*
    begin
        nxt_cnt = cnt_ff;
        nxt_dec = dec_ff;
        if (running_ff && cnt_ff != 16'h0)
        begin
            case (mode_ff)
                `MODE_RELOAD:
                begin
                    if (abort_a)
                        nxt_cnt = delay_ff;
                    else if (tick)
                        nxt_cnt = cnt_ff - 16'h1;
                end
                `MODE_EXTEND:
                begin
                    if (abort_a)
                        nxt_cnt = full_ext;
                    else if (tick)
                        nxt_cnt = cnt_ff - 16'h1;
                end
                `MODE_FREEZE:
                begin
                    if (!abort_a && tick)
                        nxt_cnt = cnt_ff - 16'h1;
                end
                `MODE_FLOOR, `MODE_NOINT:
                begin
                    if (abort_a && !(mode_ff == `MODE_NOINT && dec_ff))
                    begin
                        if (abort_rise && cnt_ff < `FLOOR_SEC)
                            nxt_cnt = `FLOOR_SEC;
                        else if (tick && cnt_ff > `FLOOR_SEC)
                            nxt_cnt = cnt_ff - 16'h1;
                    end
                    else if (tick)
                        nxt_cnt = cnt_ff - 16'h1;
                end
                default:
                begin
                    if (tick)
                        nxt_cnt = cnt_ff - 16'h1;
                end
            endcase
            if (nxt_cnt != cnt_ff && nxt_cnt < cnt_ff)
                nxt_dec = 1'b1;
        end
    end
    // countdown state
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_ff <= 16'h0;
            started_ff <= 1'b0;
            dec_ff <= 1'b0;
            countdown_done <= 1'b0;
            abort_d_ff <= 1'b0;
            heat_d_ff <= 1'b0;
        end
        else
        begin
            abort_d_ff <= abort_a;
            heat_d_ff <= heat_a;
            if (running_ff && !started_ff)
            begin
                started_ff <= 1'b1;
                cnt_ff <= delay_ff;
            end
            else if (started_ff)
            begin
                cnt_ff <= nxt_cnt;
                dec_ff <= nxt_dec;
                if (nxt_cnt == 16'h0)
                    countdown_done <= 1'b1;
            end
        end
    end
    // release output timing and thermal cycling
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rel_ff <= 1'b0;
            act_cnt_ff <= 16'h0;
            cyc_cnt_ff <= 8'h0;
            min_ff <= 6'h0;
            cyc_on_ff <= 1'b0;
            first_ff <= 1'b1;
            latched_ff <= 1'b0;
            act_fired_ff <= 1'b0;
        end
        else
        begin
            if (tick)
                min_ff <= (min_ff == 6'h3b) ? 6'h0 : min_ff + 6'h1;
            if (countdown_done)
            begin
                case (act_ff)
                    `ACT_CONT:
                        rel_ff <= 1'b1;
                    `ACT_THERM:
                    begin
                        if (other_a)
                            latched_ff <= 1'b1;
                        if (latched_ff || other_a)
                            rel_ff <= 1'b1;
                        else if (!cyc_on_ff)
                        begin
                            rel_ff <= 1'b0;
                            if (heat_a && (first_ff || heat_rise || cyc_cnt_ff == 8'h0))
                            begin
                                cyc_on_ff <= 1'b1;
                                cyc_cnt_ff <= cut_len;
                                min_ff <= 6'h0;
                            end
                        end
                        else
                        begin
                            rel_ff <= (cyc_cnt_ff != 8'h0);
                            if (cyc_cnt_ff == 8'h0)
                            begin
                                cyc_on_ff <= 1'b0;
                                first_ff <= 1'b0;
                            end
                            else if (unit_tick)
                                cyc_cnt_ff <= cyc_cnt_ff - 8'h1;
                        end
                    end
                    default:
                    begin
                        if (!rel_ff && !act_fired_ff)
                        begin
                            rel_ff <= 1'b1;
                            act_fired_ff <= 1'b1;
                            act_cnt_ff <= act_len;
                        end
                        else if (rel_ff && tick)
                        begin
                            act_cnt_ff <= act_cnt_ff - 16'h1;
                            if (act_cnt_ff == 16'h1)
                                rel_ff <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end
    // per-group release drive
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            release_out <= {NMOD{1'b0}};
        else
            for (i = 0; i < NMOD; i = i + 1)
                release_out[i] <= rel_ff & |(grp_ff[4*i +: 4] & rel_grp_ff);
    end
    // bus slave
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            addr_ff <= 12'h0;
            mode_ff <= `MODE_RELOAD;
            act_ff <= `ACT_90S;
            running_ff <= 1'b0;
            delay_ff <= `DELAY_RST;
            pol_ff <= 3'h0;
            modcfg_ff <= {3*NMOD{1'b0}};
            itl_ff <= 8'h0;
            ctl_ff <= 8'h0;
            unit_min_ff <= 1'b0;
            grp_ff <= {4*NMOD{1'b0}};
            rel_grp_ff <= {NGRP{1'b0}};
            mod_idx_ff <= 4'h0;
        end
        else
        begin
            wr_ff <= hsel & hready & htrans[1] & hwrite;
            rd_ff <= hsel & hready & htrans[1] & ~hwrite;
            if (hsel & hready & htrans[1])
                addr_ff <= haddr;
            if (wr_ff)
            begin
                case (addr_ff)
                    `REG_CTRL:
                    begin
                        mode_ff <= hwdata[`CTRL_MODE_LSB +: 3];
                        act_ff <= hwdata[`CTRL_ACT_LSB +: 3];
                        if (hwdata[`CTRL_START_BIT])
                            running_ff <= 1'b1;
                    end
                    `REG_DELAY:
                        delay_ff <= hwdata[15:0];
                    `REG_POL:
                        pol_ff <= hwdata[2:0];
                    `REG_MOD:
                    begin
                        modcfg_ff[3*hwdata[19:16] +: 3] <= hwdata[2:0];
                        mod_idx_ff <= hwdata[19:16];
                    end
                    `REG_CYCLE:
                    begin
                        itl_ff <= (hwdata[7:0] > `CUTOFF_MAX) ? `CUTOFF_MAX : hwdata[7:0];
                        ctl_ff <= (hwdata[15:8] > `CUTOFF_MAX) ? `CUTOFF_MAX : hwdata[15:8];
                        unit_min_ff <= hwdata[16];
                    end
                    `REG_GROUP:
                    begin
                        grp_ff[4*hwdata[19:16] +: 4] <= hwdata[3:0];
                        rel_grp_ff <= hwdata[NGRP+7:8];
                    end
                    default:
                        mode_ff <= mode_ff;
                endcase
            end
        end
    end
    // read data
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0;
        else if (hsel & hready & htrans[1] & ~hwrite)
        begin
            case (haddr)
                `REG_CTRL:
                    hrdata <= {23'h0, running_ff, 1'b0, act_ff, 1'b0, mode_ff};
                `REG_DELAY:
                    hrdata <= {16'h0, delay_ff};
                `REG_POL:
                    hrdata <= {29'h0, pol_ff};
                `REG_MOD:
                    hrdata <= {12'h0, mod_idx_ff, 13'h0, modcfg_ff[3*mod_idx_ff +: 3]};
                `REG_CYCLE:
                    hrdata <= {15'h0, unit_min_ff, ctl_ff, itl_ff};
                `REG_STATUS:
                    hrdata <= {11'h0, latched_ff, cyc_on_ff, rel_ff, countdown_done,
                               abort_a, cnt_ff};
                default:
                    hrdata <= 32'h0;
            endcase
        end
    end
endmodule

/* File: rtl/release_ctl_defs.vh */
// constants for the release countdown and release output block
`ifndef RELEASE_CTL_DEFS_VH
`define RELEASE_CTL_DEFS_VH
// register byte offsets
`define REG_CTRL 12'h000
`define REG_DELAY 12'h004
`define REG_POL 12'h008
`define REG_MOD 12'h00c
`define REG_CYCLE 12'h010
`define REG_STATUS 12'h014
`define REG_GROUP 12'h018
// ctrl fields
`define CTRL_MODE_LSB 0
`define CTRL_ACT_LSB 4
`define CTRL_START_BIT 8
`define CTRL_RESET_BIT 9
// abort modes
`define MODE_RELOAD 3'h0
`define MODE_FLOOR 3'h1
`define MODE_EXTEND 3'h2
`define MODE_FREEZE 3'h3
`define MODE_NOINT 3'h4
// activation choices
`define ACT_90S 3'h0
`define ACT_10M 3'h1
`define ACT_15M 3'h2
`define ACT_CONT 3'h3
`define ACT_THERM 3'h4
// timing in seconds (CUTOFF_MAX in seconds or minutes per cycle unit), clock rate in hertz
`define FLOOR_SEC 16'h000a
`define EXTRA_SEC 16'h005a
`define ACT90_SEC 16'h005a
`define ACT10M_SEC 16'h0258
`define ACT15M_SEC 16'h0384
`define CUTOFF_MAX 8'hb4
`define CLK_HZ 10000000
// reset values
`define DELAY_RST 16'h001e
`endif

/* File: verif/contact_field_model.sv */
// field contacts: raw contact level from active condition and wiring polarity
`timescale 1ns/1ps
module contact_field_model (
    // active conditions
    input wire logic abort_act,
    input wire logic heat_act,
    input wire logic alarm_act,
    // wiring polarity, 1 = normally closed
    input wire logic [2:0] pol,
    // raw contact levels
    output logic abort_raw,
    output logic heat_raw,
    output logic alarm_raw
);
    assign abort_raw = abort_act ^ pol[0];
    assign heat_raw = heat_act ^ pol[1];
    assign alarm_raw = alarm_act ^ pol[2];
endmodule

/* File: verif/release_countdown_abort_control_test.sv */
// testbench for the release countdown block
`timescale 1ns/1ps
`include "release_ctl_defs.vh"
module release_countdown_abort_control_test;
    localparam SEC = 10;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [11:0] haddr = 12'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, q, q1;
    logic abort_act = 1'b0, heat_act = 1'b0, alarm_act = 1'b0;
    logic [2:0] pol = 3'h0;
    wire abort_raw, heat_raw, alarm_raw, hready, hresp, countdown_done;
    wire [31:0] hrdata;
    wire [15:0] release_out;
    int num_errors = 0, total_checks = 0, cycles = 0, n;
    initial forever #50 hclk = ~hclk;
    contact_field_model fld_u (.abort_act(abort_act), .heat_act(heat_act),
        .alarm_act(alarm_act), .pol(pol), .abort_raw(abort_raw), .heat_raw(heat_raw),
        .alarm_raw(alarm_raw));
    release_countdown_abort_control #(.SEC_CYCLES(SEC)) dut_u (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
        .hresp(hresp), .abort_in(abort_raw), .heat_in(heat_raw),
        .alarm_initiating_input(alarm_raw), .release_out(release_out),
        .countdown_done(countdown_done));
    task finish_test;
        if (num_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask
    task wait_s(input int s);
        repeat (s * SEC) @(posedge hclk);
    endtask
    task rst;
        abort_act <= 1'b0;
        heat_act <= 1'b0;
        alarm_act <= 1'b0;
        pol <= 3'h0;
        hresetn <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
    endtask
    task start(input logic [2:0] m, input logic [2:0] act, input logic [15:0] dly);
        rst();
        ahb(1'b1, `REG_GROUP, 32'h0000_0101);
        ahb(1'b1, `REG_DELAY, {16'h0, dly});
        ahb(1'b1, `REG_CTRL, {23'h0, 1'b1, 1'b0, act, 1'b0, m});
    endtask
    task wait_done;
        n = 0;
        while (countdown_done !== 1'b1 && n < 3000)
        begin
            @(posedge hclk);
            n++;
        end
        chk(countdown_done, 1'b1);
    endtask
    task t_regs;
        ahb(1'b0, `REG_DELAY, 0);
        chk(q[15:0], `DELAY_RST);
        ahb(1'b0, 12'h01c, 0);
        chk(q, 32'h0);
        ahb(1'b0, `REG_STATUS, 0);
        chk(q, 32'h0);
        ahb(1'b1, `REG_CYCLE, 32'h0000_ffff);
        ahb(1'b0, `REG_CYCLE, 0);
        chk(q[15:0], {`CUTOFF_MAX, `CUTOFF_MAX});
        ahb(1'b1, `REG_MOD, 32'h0003_0005);
        ahb(1'b0, `REG_MOD, 0);
        chk(q, 32'h0003_0005);
    endtask
    task t_reload;
        start(`MODE_RELOAD, `ACT_CONT, 16'd20);
        wait_s(5);
        abort_act <= 1'b1;
        wait_s(3);
        ahb(1'b0, `REG_STATUS, 0);
        chk(q[16:0], {1'b1, 16'd20});
        abort_act <= 1'b0;
        wait_s(3);
        ahb(1'b0, `REG_STATUS, 0);
        chk(q[15:0] < 20 && q[15:0] > 15, 1);
        abort_act <= 1'b1;
        wait_s(1);
        ahb(1'b0, `REG_STATUS, 0);
        chk(q[15:0], 16'd20);
    endtask
    task t_floor;
        start(`MODE_FLOOR, `ACT_CONT, 16'd20);
        abort_act <= 1'b1;
        wait_s(14);
        ahb(1'b0, `REG_STATUS, 0);
        chk(q[15:0], `FLOOR_SEC);
        abort_act <= 1'b0;
        wait_s(4);
        abort_act <= 1'b1;
        wait_s(1);
        ahb(1'b0, `REG_STATUS, 0);
        chk(q[15:0], `FLOOR_SEC);
    endtask
    task t_extend;
        start(`MODE_EXTEND, `ACT_CONT, 16'd20);
        wait_s(2);
        abort_act <= 1'b1;
        wait_s(2);
        ahb(1'b0, `REG_STATUS, 0);
        chk(q[15:0], 16'd20 + `EXTRA_SEC);
        abort_act <= 1'b0;
        wait_s(3);
        abort_act <= 1'b1;
        wait_s(1);
        ahb(1'b0, `REG_STATUS, 0);
        chk(q[15:0], 16'd20 + `EXTRA_SEC);
    endtask
    task t_freeze;
        start(`MODE_FREEZE, `ACT_CONT, 16'd20);
        wait_s(3);
        abort_act <= 1'b1;
        wait_s(1);
        ahb(1'b0, `REG_STATUS, 0);
        q1 = q;
        chk(q1[15:0] < 20, 1);
        wait_s(4);
        ahb(1'b0, `REG_STATUS, 0);
        chk(q[15:0], q1[15:0]);
        abort_act <= 1'b0;
        wait_s(2);
        ahb(1'b0, `REG_STATUS, 0);
        chk(q[15:0] < q1[15:0], 1);
    endtask
    task t_noint;
        start(`MODE_NOINT, `ACT_90S, 16'd5);
        wait_s(2);
        abort_act <= 1'b1;
        wait_done();
        wait_s(1);
        chk(release_out, 16'h0001);
        wait_s(95);
        chk(release_out, 16'h0000);
    endtask
    task t_therm;
        start(`MODE_RELOAD, `ACT_THERM, 16'd3);
        pol <= 3'h7;
        ahb(1'b1, `REG_POL, 32'h7);
        ahb(1'b1, `REG_CYCLE, 32'h0000_0505);
        ahb(1'b0, `REG_STATUS, 0);
        chk(q[16], 1'b0);
        wait_done();
        heat_act <= 1'b1;
        wait_s(1);
        chk(release_out[0], 1'b1);
        alarm_act <= 1'b1;
        wait_s(1);
        alarm_act <= 1'b0;
        heat_act <= 1'b0;
        wait_s(8);
        ahb(1'b0, `REG_STATUS, 0);
        chk(q[20], 1'b1);
        chk(release_out[0], 1'b1);
    endtask
    task t_cycle;
        start(`MODE_RELOAD, `ACT_THERM, 16'd3);
        ahb(1'b1, `REG_CYCLE, 32'h0001_0101);
        wait_done();
        heat_act <= 1'b1;
        wait_s(2);
        heat_act <= 1'b0;
        wait_s(50);
        chk(release_out, 16'h0001);
        wait_s(12);
        chk(release_out, 16'h0000);
        heat_act <= 1'b1;
        wait_s(2);
        ahb(1'b0, `REG_STATUS, 0);
        chk(q[20:18], 3'h3);
    endtask
    task t_act(input logic [2:0] act, input int secs, input logic [15:0] late);
        start(`MODE_FREEZE, act, 16'd2);
        wait_done();
        wait_s(secs - 1);
        chk(release_out, 16'h0001);
        wait_s(2);
        chk(release_out, late);
    endtask
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            num_errors++;
            finish_test();
        end
    end
    initial
    begin
        rst();
        t_regs();
        t_reload();
        t_floor();
        t_extend();
        t_freeze();
        t_noint();
        rst();
        t_regs();
        t_therm();
        t_cycle();
        t_act(`ACT_10M, `ACT10M_SEC, 16'h0000);
        t_act(`ACT_15M, `ACT15M_SEC, 16'h0000);
        t_act(`ACT_CONT, 30, 16'h0001);
        finish_test();
    end
endmodule

/* File: verif/release_ctl_checker.sv */
// bus and release output checks on the top ports
`timescale 1ns/1ps
module release_ctl_checker #(
    parameter NMOD = 16
)(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire [NMOD-1:0] release_out,
    input wire countdown_done
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire rd_req = hsel && hready && htrans[1] && !hwrite;
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("hreadyout low");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("hresp not okay");
    property p_done_sticky; countdown_done |=> countdown_done; endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done dropped");
    property p_rel_done; release_out != 0 |-> countdown_done; endproperty
    a_rel_done: assert property (p_rel_done) else $error("release before zero");
    property p_rd_hold; $changed(hrdata) |-> $past(rd_req); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("hrdata changed");
    property p_unmapped; rd_req && haddr > 12'h018 |=> hrdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_st_done; rd_req && haddr == 12'h014 && countdown_done |=> hrdata[17]; endproperty
    a_st_done: assert property (p_st_done) else $error("status done bit");
    property p_st_zero; rd_req && haddr == 12'h014 && countdown_done |=> hrdata[15:0] == 0;
    endproperty
    a_st_zero: assert property (p_st_zero) else $error("count not zero at done");
endmodule
bind release_countdown_abort_control release_ctl_checker #(.NMOD(NMOD)) chk_u (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .release_out(release_out), .countdown_done(countdown_done));
